//--- hdl/supervisor_pkg.sv
package supervisor_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PWR_CFG   = 10'h0C5;
  localparam logic [9:0] IDX_CAL_VAL   = 10'h0E4;
  localparam logic [9:0] IDX_KILL_KEY  = 10'h0C0;
  localparam logic [9:0] IDX_EXC_CTRL  = 10'h0D0;
  localparam logic [9:0] IDX_RUN_CTRL  = 10'h0D1;
  localparam logic [9:0] IDX_STATUS    = 10'h0E6;
  localparam logic [9:0] IDX_HOURS     = 10'h0E8;
  localparam logic [9:0] IDX_MIN_SEC   = 10'h0E9;

  localparam logic [31:0] KILL_KEY      = 32'h48DB_A399;
  localparam logic [31:0] PWR_CFG_RESET = 32'h0000_0200;
  localparam logic [31:0] KEY_RESET     = 32'h0000_0000;
  localparam int unsigned CFG_MODE_BIT   = 0;
  localparam int unsigned CFG_RATE_LSB   = 4;
  localparam int unsigned CFG_SETTLE_LSB = 8;
  localparam int unsigned EXC_REQ_BIT    = 0;
  localparam int unsigned RUN_SEL_BIT    = 0;

  localparam int unsigned WDT_TIMEOUT_S  = 13;
  localparam int unsigned WDT_OSC_HZ     = 10_000;
  localparam int unsigned WDT_TICKS_DEF  = WDT_TIMEOUT_S * WDT_OSC_HZ;
  localparam int unsigned SLOW_HZ        = 32_768;
  localparam int unsigned SLOW_PER_SEC_DEF = SLOW_HZ;
  localparam int unsigned SS_SLOW_HZ     = 32_000;
  localparam int unsigned FAST_LO_HZ     = 4_000_000;
  localparam int unsigned FAST_HI_HZ     = 8_000_000;
  localparam logic [7:0]  DIV_LO = 8'(FAST_LO_HZ / SS_SLOW_HZ);
  localparam logic [7:0]  DIV_HI = 8'(FAST_HI_HZ / SS_SLOW_HZ);
  localparam logic [1:0]  CAL_LAST_PERIOD = 2'h3;
  localparam logic [7:0]  SEC_MAX = 8'h3B;
  localparam logic [7:0]  MIN_MAX = 8'h3B;
  localparam logic [3:0]  PIN_RESET = 4'h8;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [17:0] hours;
    logic [7:0]  minutes;
    logic [7:0]  seconds;
  } stamp_s;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_SETTLE,
    CAL_ALIGN,
    CAL_COUNT
  } cal_state_e;
endpackage : supervisor_pkg

//--- hdl/supervisor_service.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_service
  import supervisor_pkg::*;
#(
  parameter int unsigned WDT_TICKS    = WDT_TICKS_DEF,
  parameter int unsigned SLOW_PER_SEC = SLOW_PER_SEC_DEF
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        SLOW_OSC_IN,
  input  wire logic        FAST_OSC_IN,
  input  wire logic        WDT_OSC_IN,
  input  wire logic        LOW_POWER_SELECT_PIN,
  input  wire logic        WDT_CLEAR,
  input  wire logic        MEAS_TRIGGER,
  input  wire logic        MEAS_REQ,
  input  wire logic        HOST_CAL_CMD,
  output logic             CHIP_RESET,
  output logic             FAST_OSC_EN,
  output logic             FAST_CLK_READY,
  output logic             LOW_POWER_MODE
);
  localparam int unsigned WDT_W = $clog2(WDT_TICKS + 1);
  localparam int unsigned SPS_W = $clog2(SLOW_PER_SEC + 1);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TICKS - 1);
  localparam logic [SPS_W-1:0] SEC_LAST = SPS_W'(SLOW_PER_SEC - 1);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [6:0] rate_div(input logic [2:0] code);
    logic [6:0] d;
    d = 7'h00;
    unique case (code)
      3'h0: d = 7'h00;
      3'h1: d = 7'h01;
      3'h2: d = 7'h02;
      3'h3: d = 7'h05;
      3'h4: d = 7'h0A;
      3'h5: d = 7'h14;
      3'h6: d = 7'h32;
      3'h7: d = 7'h64;
    endcase
    return d;
  endfunction : rate_div

  // Pin inputs: three flops, a change counts once stages two and three agree
  logic [3:0] pin_in;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] flt_r;
  logic [3:0] flt_d_r;
  logic [3:0] rise;
  assign pin_in = {LOW_POWER_SELECT_PIN, WDT_OSC_IN, FAST_OSC_IN, SLOW_OSC_IN};
  assign rise   = flt_r & ~flt_d_r;

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        s1_r[i]    <= PIN_RESET[i];
        s2_r[i]    <= PIN_RESET[i];
        s3_r[i]    <= PIN_RESET[i];
        flt_r[i]   <= PIN_RESET[i];
        flt_d_r[i] <= PIN_RESET[i];
      end else if (CE) begin
        s1_r[i] <= pin_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          flt_r[i] <= s3_r[i];
        end
        flt_d_r[i] <= flt_r[i];
      end
    end
  end

  // Registers
  logic [31:0]  cfg_r;
  logic [31:0]  key_r;
  logic         sel_r;
  logic [31:0]  cal_val_r;
  logic         cal_new_r;
  stamp_s       live_r;
  stamp_s       latch_r;

  logic         low_power_select_pin;
  logic         stamp_mode;
  logic [2:0]   cal_rate;
  logic [3:0]   settle_time;
  assign low_power_select_pin        = flt_r[3];
  assign LOW_POWER_MODE = low_power_select_pin;
  assign stamp_mode     = cfg_r[CFG_MODE_BIT];
  assign cal_rate       = cfg_r[CFG_RATE_LSB +: 3];
  assign settle_time    = cfg_r[CFG_SETTLE_LSB +: 4];

  // AXI4-Lite slave
  logic        aw_have_r;
  logic        w_have_r;
  logic [9:0]  aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        do_write;
  logic        do_read;
  logic [9:0]  ar_idx;
  logic        wr_cfg;
  logic        wr_key;
  logic        wr_run;
  logic        wr_exc;
  logic        wr_hit;
  logic        rd_hit;
  logic        rd_cal;
  logic [31:0] rd_data;

  assign AWREADY  = CE & ~aw_have_r & ~bvalid_r;
  assign WREADY   = CE & ~w_have_r & ~bvalid_r;
  assign ARREADY  = CE & ~rvalid_r;
  assign BVALID   = bvalid_r;
  assign BRESP    = bresp_r;
  assign RVALID   = rvalid_r;
  assign RRESP    = rresp_r;
  assign RDATA    = rdata_r;
  assign do_write = CE & aw_have_r & w_have_r & ~bvalid_r;
  assign do_read  = ARVALID & ARREADY;
  assign ar_idx   = ARADDR[11:2];
  assign wr_cfg   = do_write & (aw_idx_r == IDX_PWR_CFG);
  assign wr_key   = do_write & (aw_idx_r == IDX_KILL_KEY);
  assign wr_run   = do_write & (aw_idx_r == IDX_RUN_CTRL);
  assign wr_exc   = do_write & (aw_idx_r == IDX_EXC_CTRL);
  assign wr_hit   = (aw_idx_r == IDX_PWR_CFG) | (aw_idx_r == IDX_KILL_KEY) |
                    (aw_idx_r == IDX_RUN_CTRL) | (aw_idx_r == IDX_EXC_CTRL) |
                    (aw_idx_r == IDX_CAL_VAL) | (aw_idx_r == IDX_STATUS) |
                    (aw_idx_r == IDX_HOURS) | (aw_idx_r == IDX_MIN_SEC);
  assign rd_cal   = do_read & (ar_idx == IDX_CAL_VAL);
  assign rd_hit   = (ar_idx == IDX_PWR_CFG) | (ar_idx == IDX_KILL_KEY) |
                    (ar_idx == IDX_RUN_CTRL) | (ar_idx == IDX_EXC_CTRL) |
                    (ar_idx == IDX_CAL_VAL) | (ar_idx == IDX_STATUS) |
                    (ar_idx == IDX_HOURS) | (ar_idx == IDX_MIN_SEC);
  assign rd_data  =
    (ar_idx == IDX_PWR_CFG)  ? cfg_r :
    (ar_idx == IDX_KILL_KEY) ? key_r :
    (ar_idx == IDX_RUN_CTRL) ? {31'h0, sel_r} :
    (ar_idx == IDX_CAL_VAL)  ? cal_val_r :
    (ar_idx == IDX_STATUS)   ? {28'h0, (key_r != KILL_KEY), FAST_CLK_READY,
                                low_power_select_pin, cal_new_r} :
    (ar_idx == IDX_HOURS)    ? {14'h0, latch_r.hours} :
    (ar_idx == IDX_MIN_SEC)  ? {16'h0, latch_r.minutes,
                                latch_r.seconds} :
    32'h0;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_idx_r  <= 10'h000;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (CE) begin
      if (AWVALID & AWREADY) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= AWADDR[11:2];
      end
      if (WVALID & WREADY) begin
        w_have_r <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r & BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (CE) begin
      if (do_read) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rd_data;
      end else if (rvalid_r & RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Partial writes merge into the key, so several byte-lane writes can build up a matching key
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_r <= PWR_CFG_RESET;
      key_r <= KEY_RESET;
      sel_r <= 1'b0;
    end else if (CE) begin
      if (wr_cfg) begin
        cfg_r <= merge(cfg_r, wdata_r, wstrb_r);
      end
      if (wr_key) begin
        key_r <= merge(key_r, wdata_r, wstrb_r);
      end
      if (wr_run & wstrb_r[0]) begin
        sel_r <= wdata_r[RUN_SEL_BIT];
      end
    end
  end

  // Watchdog on the 10 kHz oscillator ticks
  logic             wdt_en;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic             chip_rst_r;
  assign wdt_en     = (key_r != KILL_KEY);
  assign CHIP_RESET = chip_rst_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wdt_cnt_r  <= '0;
      chip_rst_r <= 1'b0;
    end else if (CE) begin
      chip_rst_r <= 1'b0;
      if (WDT_CLEAR | ~wdt_en) begin
        wdt_cnt_r <= '0;
      end else if (rise[2]) begin
        if (wdt_cnt_r == WDT_LAST) begin
          wdt_cnt_r  <= '0;
          chip_rst_r <= 1'b1;
        end else begin
          wdt_cnt_r <= wdt_cnt_r + 1'b1;
        end
      end
    end
  end

  // Slow tick: slow oscillator, or divided fast clock in single source
  logic [7:0]       div_cnt_r;
  logic [7:0]       div_last;
  logic             div_tick;
  logic             slow_tick;
  logic [SPS_W-1:0] sec_cnt_r;
  logic             sec_tick;
  assign div_last  = (sel_r ? DIV_HI : DIV_LO) - 8'h01;
  assign div_tick  = rise[1] & (div_cnt_r == div_last);
  assign slow_tick = low_power_select_pin ? rise[0] : div_tick;
  assign sec_tick  = low_power_select_pin & slow_tick & (sec_cnt_r == SEC_LAST);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      div_cnt_r <= 8'h00;
      sec_cnt_r <= '0;
    end else if (CE) begin
      if (rise[1]) begin
        div_cnt_r <= div_tick ? 8'h00 : div_cnt_r + 8'h01;
      end
      if (low_power_select_pin & slow_tick) begin
        sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 1'b1;
      end
    end
  end

  // Elapsed time counter and its latch
  logic stamp_req;
  logic stamp_load;
  assign stamp_req  = wr_exc & wstrb_r[0] & wdata_r[EXC_REQ_BIT];
  assign stamp_load = stamp_req | (stamp_mode & sec_tick);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      live_r  <= '0;
      latch_r <= '0;
    end else if (CE) begin
      if (sec_tick) begin
        if (live_r.seconds != SEC_MAX) begin
          live_r.seconds <= live_r.seconds + 8'h01;
        end else begin
          live_r.seconds <= 8'h00;
          if (live_r.minutes != MIN_MAX) begin
            live_r.minutes <= live_r.minutes + 8'h01;
          end else begin
            live_r.minutes <= 8'h00;
            live_r.hours   <= live_r.hours + 18'h00001;
          end
        end
      end
      if (stamp_load) begin
        latch_r <= live_r;
      end
    end
  end

  // Fast oscillator control and settling
  cal_state_e  cal_state_r;
  logic [3:0]  settle_cnt_r;
  logic        ready_r;
  assign FAST_OSC_EN = ~low_power_select_pin | MEAS_REQ |
                       (cal_state_r != CAL_IDLE);
  assign FAST_CLK_READY = ready_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      settle_cnt_r <= 4'h0;
      ready_r      <= 1'b0;
    end else if (CE) begin
      if (~FAST_OSC_EN) begin
        settle_cnt_r <= 4'h0;
        ready_r      <= 1'b0;
      end else if (settle_cnt_r >= settle_time) begin
        ready_r <= 1'b1;
      end else if (slow_tick) begin
        settle_cnt_r <= settle_cnt_r + 4'h1;
      end
    end
  end

  // Calibration scheduling and measurement
  logic [6:0]  trig_cnt_r;
  logic [6:0]  div_n;
  logic        seq_req;
  logic        cal_start;
  logic [1:0]  period_r;
  logic [15:0] fast_cnt_r;
  logic        cal_done;
  assign div_n     = rate_div(cal_rate);
  assign seq_req   = MEAS_TRIGGER & (div_n != 7'h00) &
                     ((trig_cnt_r + 7'h01) >= div_n);
  assign cal_start = (seq_req | HOST_CAL_CMD) &
                     (cal_state_r == CAL_IDLE);
  assign cal_done  = (cal_state_r == CAL_COUNT) & slow_tick &
                     (period_r == CAL_LAST_PERIOD);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      trig_cnt_r <= 7'h00;
    end else if (CE & MEAS_TRIGGER) begin
      trig_cnt_r <= (seq_req | (div_n == 7'h00)) ? 7'h00 : trig_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cal_state_r <= CAL_IDLE;
      period_r    <= 2'h0;
      fast_cnt_r  <= 16'h0000;
    end else if (CE) begin
      unique case (cal_state_r)
        CAL_IDLE:   if (cal_start) cal_state_r <= CAL_SETTLE;
        CAL_SETTLE: if (ready_r) cal_state_r <= CAL_ALIGN;
        CAL_ALIGN: begin
          period_r   <= 2'h0;
          fast_cnt_r <= 16'h0000;
          if (slow_tick) cal_state_r <= CAL_COUNT;
        end
        CAL_COUNT: begin
          if (rise[1]) fast_cnt_r <= fast_cnt_r + 16'h0001;
          if (slow_tick) period_r <= period_r + 2'h1;
          if (cal_done) cal_state_r <= CAL_IDLE;
        end
      endcase
    end
  end

  // Fresh result wins over a clearing read in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cal_val_r <= 32'h0;
      cal_new_r <= 1'b0;
    end else if (CE) begin
      if (cal_done) begin
        cal_val_r <= {fast_cnt_r, 16'h0000};
        cal_new_r <= 1'b1;
      end else if (rd_cal) begin
        cal_new_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  wdt_boot_a: assert property ($fell(RST) |-> wdt_en)
    else $error("watchdog not enabled after reset");
  wdt_fire_a: assert property (CHIP_RESET |-> $past(wdt_cnt_r) == WDT_LAST
    && $past(rise[2]) && $past(wdt_en))
    else $error("chip reset without full timeout");
  wdt_clear_a: assert property (CE && WDT_CLEAR |=> wdt_cnt_r == '0)
    else $error("watchdog clear ignored");
  wdt_kill_a: assert property ($past(key_r) == KILL_KEY |-> !CHIP_RESET)
    else $error("reset while watchdog killed");
  stamp_req_a: assert property (CE && stamp_req |=> latch_r == $past(live_r))
    else $error("latch request not taken");
  stamp_hold_a: assert property (!stamp_load |=> $stable(latch_r))
    else $error("latch changed without cause");
  ss_frozen_a: assert property (!low_power_select_pin |=> $stable(live_r))
    else $error("stamp counts in single source");
  ss_osc_a: assert property (!low_power_select_pin |-> FAST_OSC_EN)
    else $error("fast oscillator off in single source");
  cal_flag_a: assert property ($rose(cal_new_r) |->
    $past(cal_state_r) == CAL_COUNT && cal_state_r == CAL_IDLE)
    else $error("calibration flag without result");
  cal_settled_a: assert property (cal_state_r == CAL_COUNT |-> ready_r)
    else $error("calibration on unsettled clock");
  cal_off_a: assert property (div_n == 7'h00 && !HOST_CAL_CMD |-> !cal_start)
    else $error("calibration started while off");

  wdt_fire_c: cover property (CHIP_RESET);
  auto_latch_c: cover property (stamp_mode && sec_tick);
  cal_done_c: cover property (cal_done);
endmodule : supervisor_service
`default_nettype wire

//--- tb/osc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module osc_partner #(
  parameter int SLOW_HALF = 101,
  parameter int FAST_HALF = 26, // One fixed rate, never 8 MHz
  parameter int WDT_HALF  = 51
) (
  input  wire logic fast_en,
  input  wire logic lp_pin,
  output logic      slow_osc,
  output logic      fast_osc,
  output logic      wdt_osc
);
  initial begin
    slow_osc = 1'b0;
    fast_osc = 1'b0;
    wdt_osc  = 1'b0;
  end
  // Slow input is grounded on single source boards
  always #(SLOW_HALF) slow_osc = lp_pin ? ~slow_osc : 1'b0;
  // A stopped resonator sits low, not at its last phase
  always #(FAST_HALF) fast_osc = fast_en ? ~fast_osc : 1'b0;
  always #(WDT_HALF) wdt_osc = ~wdt_osc;
endmodule : osc_partner
`default_nettype wire

//--- tb/supervisor_service_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_service_tb;
  import supervisor_pkg::*;
  localparam int WDTT = 20;
  localparam int SPS  = 8;
  localparam int SH   = 101;
  localparam int FH   = 26;
  localparam int WH   = 51;
  logic        CORE_CLK, RST, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d, v, e, t, t2;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, r;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, en_q;
  logic        SLOW_OSC_IN, FAST_OSC_IN, WDT_OSC_IN, LOW_POWER_SELECT_PIN;
  logic        WDT_CLEAR, MEAS_TRIGGER, MEAS_REQ, HOST_CAL_CMD;
  logic        CHIP_RESET, FAST_OSC_EN, FAST_CLK_READY, LOW_POWER_MODE;
  int          fail_count, compares, slow_cnt, cr_cnt, starts, n, st, sp;
  integer      seed;
  logic [31:0] mdl [int];
  int          rate [8] = '{0, 1, 2, 5, 10, 20, 50, 100};

  supervisor_service #(.WDT_TICKS(WDTT), .SLOW_PER_SEC(SPS))
    supervisor_service_i (.CORE_CLK, .RST, .CE, .AWADDR, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .SLOW_OSC_IN, .FAST_OSC_IN, .WDT_OSC_IN, .LOW_POWER_SELECT_PIN,
    .WDT_CLEAR, .MEAS_TRIGGER, .MEAS_REQ, .HOST_CAL_CMD, .CHIP_RESET,
    .FAST_OSC_EN, .FAST_CLK_READY, .LOW_POWER_MODE);
  osc_partner #(.SLOW_HALF(SH), .FAST_HALF(FH), .WDT_HALF(WH))
    osc_partner_i (.fast_en(FAST_OSC_EN), .lp_pin(LOW_POWER_SELECT_PIN),
    .slow_osc(SLOW_OSC_IN), .fast_osc(FAST_OSC_IN), .wdt_osc(WDT_OSC_IN));

  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    en_q <= FAST_OSC_EN;
    if (CHIP_RESET === 1'b1) cr_cnt <= cr_cnt + 1;
    if (FAST_OSC_EN === 1'b1 && en_q === 1'b0) starts <= starts + 1;
  end
  always @(posedge SLOW_OSC_IN) slow_cnt <= slow_cnt + 1;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] ex, got);
    compares++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic chkr(input string nm, input logic [31:0] lo, hi, got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chkr

  task automatic tick(input int c);
    repeat (c) @(posedge CORE_CLK);
  endtask : tick

  task automatic wr(input logic [9:0] a, input logic [31:0] dd,
                    input logic [3:0] s, output logic [1:0] rr);
    @(posedge CORE_CLK);
    AWADDR  <= {a, 2'h0};
    WDATA   <= dd;
    WSTRB   <= s;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    forever begin
      @(posedge CORE_CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID === 1'b1) break;
    end
    rr = BRESP;
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [31:0] dd,
                    output logic [1:0] rr);
    @(posedge CORE_CLK);
    ARADDR  <= {a, 2'h0};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    forever begin
      @(posedge CORE_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID === 1'b1) break;
    end
    dd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask : rd

  // Byte lanes merge into the model as they do into the register
  task automatic wrm(input logic [9:0] a, input logic [31:0] dd,
                     input logic [3:0] s);
    logic [1:0] rr;
    wr(a, dd, s, rr);
    chk("bresp", 32'(RESP_OKAY), 32'(rr));
    for (int i = 0; i < 4; i++)
      if (s[i] && mdl.exists(int'(a))) mdl[int'(a)][8*i+:8] = dd[8*i+:8];
  endtask : wrm

  task automatic rdm(input logic [9:0] a);
    logic [31:0] dd;
    logic [1:0]  rr;
    rd(a, dd, rr);
    chk("rresp", 32'(RESP_OKAY), 32'(rr));
    chk("register", mdl[int'(a)], dd);
  endtask : rdm

  task automatic stamp(output logic [31:0] ts);
    logic [31:0] h, ms;
    logic [1:0]  rr;
    rd(IDX_HOURS, h, rr);
    rd(IDX_MIN_SEC, ms, rr);
    chk("stamp spare bits", 32'h0, 32'({h[31:18], ms[31:16]}));
    ts = 32'(h[17:0]) * 3600 + 32'(ms[15:8]) * 60 + 32'(ms[7:0]);
  endtask : stamp

  task automatic do_reset;
    @(posedge CORE_CLK);
    RST <= 1'b1;
    tick(6);
    RST <= 1'b0;
    slow_cnt = 0;
    cr_cnt = 0;
    mdl[IDX_PWR_CFG] = PWR_CFG_RESET;
    mdl[IDX_KILL_KEY] = KEY_RESET;
    mdl[IDX_RUN_CTRL] = 32'h0;
  endtask : do_reset

  initial begin
    #(50000 * 10);
    fail_count++;
    $display("unexpected run length expected finish seen hang");
    end_sim();
  end

  initial begin
    CORE_CLK = 1'b0; RST = 1'b1; CE = 1'b1; AWVALID = 1'b0; WVALID = 1'b0;
    BREADY = 1'b0; ARVALID = 1'b0; RREADY = 1'b0; AWADDR = '0; ARADDR = '0;
    WDATA = '0; WSTRB = '0; LOW_POWER_SELECT_PIN = 1'b1; WDT_CLEAR = 1'b0;
    MEAS_TRIGGER = 1'b0; MEAS_REQ = 1'b0; HOST_CAL_CMD = 1'b0; en_q = 1'b0;
    fail_count = 0; compares = 0; starts = 0; seed = 14;
    do_reset();
    foreach (mdl[k]) rdm(10'(k));
    rd(10'h3FF, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    wr(10'h3FF, 32'hFFFF_FFFF, 4'hF, r);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    rd(IDX_STATUS, d, r);
    chk("watchdog on at reset", 32'h1, 32'(d[3]));
    repeat (4) begin
      tick(150);
      WDT_CLEAR <= 1'b1;
      tick(1);
      WDT_CLEAR <= 1'b0;
    end
    chk("resets while cleared", 32'h0, 32'(cr_cnt));
    n = 0;
    while (cr_cnt == 0 && n < 400) begin
      tick(1);
      n++;
    end
    chkr("timeout cycles", WDTT*WH/5 - 15, WDTT*WH/5 + 15, n);
    WDT_CLEAR <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? (KILL_KEY ^ 32'h1) : $random(seed);
      wrm(IDX_KILL_KEY, v, 4'hF);
      rd(IDX_STATUS, d, r);
      chk("watchdog on", 32'(v !== KILL_KEY), 32'(d[3]));
    end
    rdm(IDX_KILL_KEY);
    wrm(IDX_KILL_KEY, 32'h0, 4'hF);
    wrm(IDX_KILL_KEY, KILL_KEY, 4'h7);
    rd(IDX_STATUS, d, r);
    chk("part key", 32'h1, 32'(d[3]));
    wrm(IDX_KILL_KEY, KILL_KEY, 4'h8);
    WDT_CLEAR <= 1'b0;
    st = cr_cnt;
    tick(400);
    chk("reset while off", 32'(st), 32'(cr_cnt));
    do_reset();
    rdm(IDX_KILL_KEY);
    rd(IDX_STATUS, d, r);
    chk("watchdog on again", 32'h1, 32'(d[3]));
    WDT_CLEAR <= 1'b1;
    tick(500);
    wrm(IDX_EXC_CTRL, 32'h1, 4'hF);
    e = slow_cnt / SPS;
    tick(500);
    stamp(t);
    chkr("requested stamp", e - 1, e + 1, t);
    wrm(IDX_EXC_CTRL, 32'h0, 4'hF);
    rd(IDX_EXC_CTRL, d, r);
    chk("request reads", 32'h0, d);
    stamp(t2);
    chk("no-op request", t, t2);
    wrm(IDX_PWR_CFG, PWR_CFG_RESET | 32'h1, 4'hF);
    tick(500);
    stamp(t);
    e = slow_cnt / SPS;
    // Auto latch holds the count from before the tick that loaded it
    chkr("auto stamp", e - 2, e, t);
    wrm(IDX_PWR_CFG, PWR_CFG_RESET, 4'hF);
    chk("fast osc idle", 32'h0, 32'(FAST_OSC_EN));
    MEAS_REQ <= 1'b1;
    tick(2);
    chk("fast osc on demand", 32'h1, 32'(FAST_OSC_EN));
    MEAS_REQ <= 1'b0;
    LOW_POWER_SELECT_PIN <= 1'b0;
    // Let the filtered pin settle so no second tick lands after the latch
    tick(6);
    wrm(IDX_EXC_CTRL, 32'h1, 4'hF);
    stamp(t);
    tick(6000);
    chk("single source mode", 32'h0, 32'(LOW_POWER_MODE));
    chk("fast osc kept on", 32'h1, 32'(FAST_OSC_EN));
    wrm(IDX_EXC_CTRL, 32'h1, 4'hF);
    stamp(t2);
    chk("stamp frozen", t, t2);
    LOW_POWER_SELECT_PIN <= 1'b1;
    tick(20);
    chk("low power mode", 32'h1, 32'(LOW_POWER_MODE));
    st = starts;
    HOST_CAL_CMD <= 1'b1;
    tick(1);
    HOST_CAL_CMD <= 1'b0;
    n = 0;
    while (FAST_CLK_READY !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    chkr("settle cycles", 20, 65, n);
    n = 0;
    do begin
      rd(IDX_STATUS, d, r);
      n++;
    end while (d[0] !== 1'b1 && n < 100);
    chk("cal flag set", 32'h1, 32'(d[0]));
    chk("host cal start", 32'(st + 1), 32'(starts));
    rd(IDX_CAL_VAL, d, r);
    chk("cal fraction", 32'h0, 32'(d[15:0]));
    chkr("cal periods", 4*SH/FH - 1, 4*SH/FH + 2, 32'(d[31:16]));
    rd(IDX_STATUS, d, r);
    chk("cal flag clear", 32'h0, 32'(d[0]));
    for (int c = 0; c < 8; c++) begin
      wrm(IDX_PWR_CFG, PWR_CFG_RESET | 32'(c << CFG_RATE_LSB), 4'hF);
      sp = (c == 0) ? 3 : 200 / rate[c] + 2;
      st = starts;
      repeat ((c == 0) ? 10 : 2 * rate[c]) begin
        MEAS_TRIGGER <= 1'b1;
        tick(1);
        MEAS_TRIGGER <= 1'b0;
        tick(sp);
      end
      tick(300);
      chk("cal runs", (c == 0) ? 32'h0 : 32'h2, 32'(starts - st));
    end
    CE <= 1'b0;
    LOW_POWER_SELECT_PIN <= 1'b0;
    tick(20);
    chk("frozen mode", 32'h1, 32'(LOW_POWER_MODE));
    chk("frozen readies", 32'h0, 32'({AWREADY, WREADY, ARREADY}));
    LOW_POWER_SELECT_PIN <= 1'b1;
    CE <= 1'b1;
    wrm(IDX_RUN_CTRL, 32'h1, 4'hF);
    rdm(IDX_RUN_CTRL);
    end_sim();
  end
endmodule : supervisor_service_tb
`default_nettype wire
